/* hdl/gcm_defs.svh */
// Constants for the global chip miscellaneous register bank
// Overview of operation
// - High-speed pad strength bits 6:4, reset 110
// - Low-speed pad strength bits 2:0, reset 010
// - Status bit 31 flags good frame
// - Status bit 30 flags response sent
// - Status bit 29 flags execution done
// - Matching tag frame clears done and errors
// - Bit 14 flags destination mismatch when checking
// - Bit 13 flags bad access-format word
// - Bit 12 flags bad access code
// - Bit 11 flags unknown command code
// - Bit 10 flags oversize frame, no response
// - Bits 6:0 locate the unknown command
// - Ten-bit pin function field, port order
// - Zero indicator, one general output; reset zero
// - General output drives level bit; reset zero
// - Level field uses same pin order
// - Destination check discards mismatching frames
`ifndef GCM_DEFS_SVH
`define GCM_DEFS_SVH

`define GCM_ADDR_PAD_DRIVE     16'h010D
`define GCM_ADDR_INBAND_STATUS 16'h0110
`define GCM_ADDR_PIN_FUNCTION  16'h0120
`define GCM_ADDR_OUT_LEVEL     16'h0124

`define GCM_PAD_HS_MSB   6
`define GCM_PAD_HS_LSB   4
`define GCM_PAD_RSV_HI   7
`define GCM_PAD_RSV_LO   3
`define GCM_PAD_LS_MSB   2
`define GCM_PAD_LS_LSB   0
`define GCM_PAD_HS_RST   3'h6
`define GCM_PAD_LS_RST   3'h2

`define GCM_ST_GOOD      31
`define GCM_ST_RESP_DONE 30
`define GCM_ST_EXEC_DONE 29
`define GCM_ST_DEST_ERR  14
`define GCM_ST_FMT_ERR   13
`define GCM_ST_CODE_ERR  12
`define GCM_ST_CMD_ERR   11
`define GCM_ST_SIZE_ERR  10
`define GCM_ST_LOC_MSB   6
`define GCM_ST_LOC_LSB   0

`define GCM_PINS_RST     10'h000

`endif

/* hdl/gcm_pkg.sv */
// Types shared by the global chip miscellaneous register bank
package gcm_pkg;

    // Register port request from the management port decoder
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [31:0] wdata;
    } gcm_reg_req_t;

    // One-cycle event pulses from the in-band frame engine
    typedef struct packed {
        logic       tag_match;  // New frame with matching tag received
        logic       good_frame;
        logic       resp_sent;
        logic       exec_done;
        logic       dest_mismatch;
        logic       fmt_err;
        logic       code_err;
        logic       cmd_err;
        logic [6:0] cmd_err_loc;
        logic       oversize;
    } gcm_inband_evt_t;

    typedef struct packed {
        logic       good;
        logic       resp_done;
        logic       exec_done;
        logic       dest_err;
        logic       fmt_err;
        logic       code_err;
        logic       cmd_err;
        logic       size_err;
        logic [6:0] err_loc;
    } gcm_status_t;

    typedef struct packed {
        logic        pad_rsv_hi;
        logic [2:0]  pad_hs;
        logic        pad_rsv_lo;
        logic [2:0]  pad_ls;
        gcm_status_t st;
        logic [9:0]  pin_fn;
        logic [9:0]  pin_lvl;
        logic [9:0]  pins;
        logic        discard;
        logic        resp_block;
        logic [31:0] rdata;
        logic        rvalid;
    } gcm_state_t;

endpackage

/* hdl/gcm_misc_regs.sv */
// Global chip miscellaneous register bank: pad strength, in-band status, indicator pin control
`timescale 1ns/1ps
`default_nettype none
`include "gcm_defs.svh"

module gcm_misc_regs #(
    parameter int PIN_COUNT = 10
) (
    input  wire logic                     clk_in,             // 200 MHz system clock
    input  wire logic                     arst_n_in,          // Asynchronous reset, active low
    input  wire gcm_pkg::gcm_reg_req_t    reg_req_in,         // Register read/write request
    output logic [31:0]                   reg_rdata_out,      // Read data, valid with rvalid
    output logic                          reg_rvalid_out,     // Read data valid pulse
    input  wire gcm_pkg::gcm_inband_evt_t inband_evt_in,      // In-band frame engine events
    input  wire logic                     inband_dest_check_enable_in, // Destination check enable
    output logic                          inband_discard_out, // Frame discard pulse
    output logic                          inband_resp_block_out, // Suppress response for this frame
    input  wire logic [PIN_COUNT-1:0]     indicator_act_in,   // Link/activity indicator levels
    output logic [PIN_COUNT-1:0]          indicator_pin_out,  // Indicator pin levels
    output logic [2:0]                    pad_hs_strength_out, // High-speed pad drive setting
    output logic [2:0]                    pad_ls_strength_out  // Low-speed pad drive setting
);
    import gcm_pkg::*;

    gcm_state_t s_q;
    gcm_state_t s_d;
    logic       dest_err_ev;
    logic       clr;

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.rdata = 32'h0000_0000;

        // Mismatch only counts while checking is on
        dest_err_ev = inband_dest_check_enable_in & inband_evt_in.dest_mismatch;
        clr = inband_evt_in.tag_match;
        s_d.discard = dest_err_ev;
        s_d.resp_block = inband_evt_in.oversize;

        // Clear first so that a same-cycle event still sets its flag
        if (clr) begin
            s_d.st.resp_done = 1'b0;
            s_d.st.exec_done = 1'b0;
            s_d.st.dest_err = 1'b0;
            s_d.st.fmt_err = 1'b0;
            s_d.st.code_err = 1'b0;
            s_d.st.cmd_err = 1'b0;
            s_d.st.size_err = 1'b0;
            s_d.st.err_loc = 7'h00;
        end
        if (inband_evt_in.good_frame) s_d.st.good = 1'b1;
        if (inband_evt_in.resp_sent) s_d.st.resp_done = 1'b1;
        if (inband_evt_in.exec_done) s_d.st.exec_done = 1'b1;
        if (dest_err_ev) s_d.st.dest_err = 1'b1;
        if (inband_evt_in.fmt_err) s_d.st.fmt_err = 1'b1;
        if (inband_evt_in.code_err) s_d.st.code_err = 1'b1;
        if (inband_evt_in.oversize) s_d.st.size_err = 1'b1;
        if (inband_evt_in.cmd_err) begin
            s_d.st.cmd_err = 1'b1;
            s_d.st.err_loc = inband_evt_in.cmd_err_loc;
        end

        // Register writes; status word takes none
        if (reg_req_in.wr) begin
            if (reg_req_in.addr == `GCM_ADDR_PAD_DRIVE) begin
                s_d.pad_rsv_hi = reg_req_in.wdata[`GCM_PAD_RSV_HI];
                s_d.pad_hs = reg_req_in.wdata[`GCM_PAD_HS_MSB:`GCM_PAD_HS_LSB];
                s_d.pad_rsv_lo = reg_req_in.wdata[`GCM_PAD_RSV_LO];
                s_d.pad_ls = reg_req_in.wdata[`GCM_PAD_LS_MSB:`GCM_PAD_LS_LSB];
            end else if (reg_req_in.addr == `GCM_ADDR_PIN_FUNCTION) begin
                s_d.pin_fn = reg_req_in.wdata[PIN_COUNT-1:0];
            end else if (reg_req_in.addr == `GCM_ADDR_OUT_LEVEL) begin
                s_d.pin_lvl = reg_req_in.wdata[PIN_COUNT-1:0];
            end
        end

        // Reads have no side effect; unmapped reads return zero
        if (reg_req_in.rd) begin
            s_d.rvalid = 1'b1;
            if (reg_req_in.addr == `GCM_ADDR_PAD_DRIVE) begin
                s_d.rdata[`GCM_PAD_RSV_HI] = s_q.pad_rsv_hi;
                s_d.rdata[`GCM_PAD_HS_MSB:`GCM_PAD_HS_LSB] = s_q.pad_hs;
                s_d.rdata[`GCM_PAD_RSV_LO] = s_q.pad_rsv_lo;
                s_d.rdata[`GCM_PAD_LS_MSB:`GCM_PAD_LS_LSB] = s_q.pad_ls;
            end else if (reg_req_in.addr == `GCM_ADDR_INBAND_STATUS) begin
                s_d.rdata[`GCM_ST_GOOD] = s_q.st.good;
                s_d.rdata[`GCM_ST_RESP_DONE] = s_q.st.resp_done;
                s_d.rdata[`GCM_ST_EXEC_DONE] = s_q.st.exec_done;
                s_d.rdata[`GCM_ST_DEST_ERR] = s_q.st.dest_err;
                s_d.rdata[`GCM_ST_FMT_ERR] = s_q.st.fmt_err;
                s_d.rdata[`GCM_ST_CODE_ERR] = s_q.st.code_err;
                s_d.rdata[`GCM_ST_CMD_ERR] = s_q.st.cmd_err;
                s_d.rdata[`GCM_ST_SIZE_ERR] = s_q.st.size_err;
                s_d.rdata[`GCM_ST_LOC_MSB:`GCM_ST_LOC_LSB] = s_q.st.err_loc;
            end else if (reg_req_in.addr == `GCM_ADDR_PIN_FUNCTION) begin
                s_d.rdata[PIN_COUNT-1:0] = s_q.pin_fn;
            end else if (reg_req_in.addr == `GCM_ADDR_OUT_LEVEL) begin
                s_d.rdata[PIN_COUNT-1:0] = s_q.pin_lvl;
            end
        end

        // Level bit only reaches the pin in general-output mode
        for (int i = 0; i < PIN_COUNT; i++) begin
            s_d.pins[i] = s_q.pin_fn[i] ? s_q.pin_lvl[i] : indicator_act_in[i];
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_q <= '0;
            s_q.pad_hs <= `GCM_PAD_HS_RST;
            s_q.pad_ls <= `GCM_PAD_LS_RST;
            s_q.pin_fn <= `GCM_PINS_RST;
            s_q.pin_lvl <= `GCM_PINS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_out = s_q.rdata;
    assign reg_rvalid_out = s_q.rvalid;
    assign inband_discard_out = s_q.discard;
    assign inband_resp_block_out = s_q.resp_block;
    assign indicator_pin_out = s_q.pins;
    assign pad_hs_strength_out = s_q.pad_hs;
    assign pad_ls_strength_out = s_q.pad_ls;

endmodule // gcm_misc_regs
`default_nettype wire

/* verif/gcm_misc_regs_props.sv */
// Port-level assertion checker for the misc register bank
`timescale 1ns/1ps
`default_nettype none
module gcm_misc_regs_props
    import gcm_pkg::*;
(
    input wire logic            clk_in,                      // Clock
    input wire logic            arst_n_in,                   // Reset, active low
    input wire gcm_reg_req_t    reg_req_in,                  // Register request
    input wire logic [31:0]     reg_rdata_out,               // Read data
    input wire logic            reg_rvalid_out,              // Read valid
    input wire gcm_inband_evt_t inband_evt_in,               // Frame events
    input wire logic            inband_dest_check_enable_in, // Destination check
    input wire logic            inband_discard_out,          // Discard pulse
    input wire logic            inband_resp_block_out        // Response block pulse
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence st_rd; reg_req_in.rd && reg_req_in.addr == 16'h0110; endsequence
    // A tag in between would legally clear the flag, so it is excluded
    sequence fmt_rd; inband_evt_in.fmt_err ##1 !inband_evt_in.tag_match ##1 st_rd; endsequence
    sequence cmd_rd;
        inband_evt_in.cmd_err ##1 !(inband_evt_in.tag_match || inband_evt_in.cmd_err) ##1 st_rd;
    endsequence
    chk_read_answer: assert property (reg_req_in.rd |=> reg_rvalid_out) else $error("read not answered");
    chk_fmt_flag: assert property (fmt_rd |=> reg_rdata_out[13]) else $error("format flag missing");
    chk_cmd_loc: assert property (cmd_rd |=> reg_rdata_out[11]
        && reg_rdata_out[6:0] == $past(inband_evt_in.cmd_err_loc, 3)) else $error("command error location wrong");
    chk_status_rsv: assert property (reg_rvalid_out && $past(reg_req_in.addr) == 16'h0110
        |-> reg_rdata_out[28:15] == 14'h0 && reg_rdata_out[9:7] == 3'h0) else $error("status reserved set");
    chk_pin_rsv: assert property (reg_rvalid_out && $past(reg_req_in.addr) inside {16'h0120, 16'h0124}
        |-> reg_rdata_out[31:10] == 22'h0) else $error("pin reserved set");
    chk_discard_on: assert property (inband_evt_in.dest_mismatch && inband_dest_check_enable_in
        |=> inband_discard_out) else $error("discard missing");
    chk_discard_off: assert property (!(inband_evt_in.dest_mismatch && inband_dest_check_enable_in)
        |=> !inband_discard_out) else $error("spurious discard");
    chk_resp_block: assert property (inband_evt_in.oversize |=> inband_resp_block_out)
        else $error("response not blocked");
endmodule // gcm_misc_regs_props
bind gcm_misc_regs gcm_misc_regs_props gcm_misc_regs_props_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .inband_evt_in(inband_evt_in), .inband_dest_check_enable_in(inband_dest_check_enable_in),
    .inband_discard_out(inband_discard_out), .inband_resp_block_out(inband_resp_block_out));
`default_nettype wire

/* verif/gcm_misc_regs_tb_top.sv */
// Self-checking bench for the misc register bank
`timescale 1ns/1ps
`default_nettype none
module gcm_misc_regs_tb_top;
    import gcm_pkg::*;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
    logic            clk_in;
    logic            arst_n_in;
    gcm_reg_req_t    req;
    gcm_inband_evt_t evt;
    logic            en;
    logic [9:0]      act;
    logic [9:0]      pins;
    logic [31:0]     rdata;
    logic            rvalid, disc, blk;
    logic [2:0]      hs, ls;
    int              fails, cmp_count, cyc;
    gcm_misc_regs gcm_misc_regs_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .inband_evt_in(evt), .inband_dest_check_enable_in(en),
        .inband_discard_out(disc), .inband_resp_block_out(blk), .indicator_act_in(act),
        .indicator_pin_out(pins), .pad_hs_strength_out(hs), .pad_ls_strength_out(ls));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_in);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge clk_in);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
    endtask
    // Event word order: tag, good, resp, exec, dest, fmt, code, cmd, loc[6:0], oversize
    task automatic ev(input gcm_inband_evt_t e, input logic en_v);
        @(posedge clk_in);
        evt <= e;
        en <= en_v;
        @(posedge clk_in);
        evt <= '0;
        #1;
        `CHK("discard", e.dest_mismatch & en_v, disc)
        `CHK("resp_block", e.oversize, blk)
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            finish_test;
        end
    end
    initial begin
        arst_n_in = 1'b0; req = '0; evt = '0; en = 1'b0; act = 10'h2AA;
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rd(16'h010D, 32'h0000_0062);
        `CHK("pad_ls", 3'h2, ls)
        rd(16'h0110, 32'h0);
        rd(16'h0120, 32'h0);
        rd(16'h0124, 32'h0);
        `CHK("pins", 10'h2AA, pins)
        $display("reset test done");
        wr(16'h010D, 32'h0000_00AD);
        rd(16'h010D, 32'h0000_00AD);
        `CHK("pad_hs", 3'h2, hs)
        `CHK("pad_ls", 3'h5, ls)
        wr(16'h0110, 32'hFFFF_FFFF);
        rd(16'h0110, 32'h0);
        rd(16'h0200, 32'h0);
        $display("pad test done");
        ev(16'h7FAB, 1'b1);
        rd(16'h0110, 32'hE000_7C55);
        ev(16'h8000, 1'b0);
        rd(16'h0110, 32'h8000_0000);
        ev(16'h0800, 1'b0);
        rd(16'h0110, 32'h8000_0000);
        // Set beats a clear arriving in the same cycle
        ev(16'h8400, 1'b1);
        rd(16'h0110, 32'h8000_2000);
        $display("status test done");
        wr(16'h0124, 32'h0000_00F0);
        // Give the new level a full cycle to reach the pins if it wrongly could
        @(posedge clk_in);
        #1;
        `CHK("pins", 10'h2AA, pins)
        wr(16'h0120, 32'hFFFF_F00F);
        rd(16'h0120, 32'h0000_000F);
        `CHK("pins", 10'h2A0, pins)
        rd(16'h0124, 32'h0000_00F0);
        $display("pin test done");
        finish_test;
    end
endmodule // gcm_misc_regs_tb_top
`default_nettype wire
